// *** inc/clk_src_pkg.sv ***
// Purpose: Shared constants and types for the sample clock source control block.
// Assumes: A 40 MHz core clock and a simple word-wide register port.
// Notes: Register addresses are the printed register numbers.
package clk_src_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;

	localparam logic [ADDR_W-1:0] ADDR_REQ_RATE = 20'h04E20;
	localparam logic [ADDR_W-1:0] ADDR_CLK_OUT_EN = 20'h04E8E;
	localparam logic [ADDR_W-1:0] ADDR_TERM = 20'h04E98;
	localparam logic [ADDR_W-1:0] ADDR_REF_FREQ = 20'h04EAC;
	localparam logic [ADDR_W-1:0] ADDR_CLK_SRC = 20'h04EE8;
	localparam logic [ADDR_W-1:0] ADDR_RATIO = 20'h30DBB;

	// Mode codes of the source selection field.
	localparam logic [DATA_W-1:0] MODE_INT_PLL = 32'h00000001;
	localparam logic [DATA_W-1:0] MODE_DIRECT_EXT = 32'h00000008;
	localparam logic [DATA_W-1:0] MODE_PLL_EXT_REF = 32'h00000020;

	localparam logic [DATA_W-1:0] REF_MIN_HZ = 32'h000F4240;
	localparam logic [DATA_W-1:0] REF_MAX_HZ = 32'h07735940;
	localparam logic [DATA_W-1:0] REF_RESET_HZ = 32'h00989680;
	localparam logic [DATA_W-1:0] RATE_RESET_HZ = 32'h00989680;
	localparam logic [DATA_W-1:0] CONV_MIN_HZ = 32'h000F4240;
	localparam logic [DATA_W-1:0] RATIO_ONE = 32'h00000001;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
	localparam int RATIO_STEPS = 11;

	// Lock wait limit and its derived cycle count.
	localparam int CORE_CLK_MHZ = 40;
	localparam int LOCK_TIMEOUT_US = 100;
	localparam int LOCK_TIMEOUT_CYC = LOCK_TIMEOUT_US * CORE_CLK_MHZ;
	localparam int LOCK_CNT_W = 13;

	typedef enum logic [2:0] {
		PLL_IDLE = 3'b001,
		PLL_LOAD = 3'b010,
		PLL_WAIT_LOCK = 3'b100
	} pll_state_e;
endpackage

// *** hdl/converter_ratio_calc.sv ***
// Purpose: Chooses the converter to sample clock ratio from the requested rate.
// Assumes: Ratio is the smallest power of two, at most 2048, lifting the rate to the converter minimum.
// Notes: Result is registered and follows a new rate after one clock.
`timescale 1ns/10ps
module converter_ratio_calc import clk_src_pkg::*; #(
	parameter logic [DATA_W-1:0] MIN_HZ = CONV_MIN_HZ
) (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic [DATA_W-1:0] rate_in,
	output logic [DATA_W-1:0] ratio_out
);
	logic [DATA_W-1:0] ratio_nxt;

	always_comb begin
		ratio_nxt = RATIO_ONE;
		for (int i = 0; i < RATIO_STEPS; i++) begin
			if (({32'h00000000, rate_in} << i) < {32'h00000000, MIN_HZ}) begin
				ratio_nxt = RATIO_ONE << (i + 1);
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ratio_out <= RATIO_ONE;
		end else begin
			ratio_out <= ratio_nxt; // R10
		end
	end

	chk_ratio_one_fast: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R11
		(rate_in >= MIN_HZ) |=> (ratio_out == RATIO_ONE))
		else $error("ratio not one for a rate at or above the converter minimum");
endmodule // converter_ratio_calc

// *** hdl/sample_clock_source_control.sv ***
// Purpose: Sample clock source selection, reference PLL control and oversampling.
// Assumes: Clock levels arriving from pins are slow enough to be sampled at 40 MHz.
// Notes: Registers sit at their printed numbers on a simple word port.
// Notes on behaviour
// (R1) Code 32 selects the internal PLL locked to the external reference.
// (R2) Code 8 uses the connector clock directly, PLL bypassed.
// (R3) In reference mode the PLL input comes from the connector, not the oscillator.
// (R4) Reference frequency is read and written in hertz, 1 MHz to 125 MHz.
// (R5) Software programs the reference equal to the clock actually supplied.
// (R6) Software writes the reference before the requested rate.
// (R7) Each rate write reprograms the PLL toward that rate; not every rate is exact.
// (R8) Termination bit set switches 50 Ohm onto the clock input, else high impedance.
// (R9) Termination acts only while the connector is an input.
// (R10) Low internal rates run the converter faster and the digital part slower.
// (R11) Read-only ratio reports converter to sample clock ratio, 1 when inactive.
// (R12) The ratio is chosen inside; writes never change it.
// (R13) Clock output drives the real converter clock, rate times ratio.
// (R14) Pipeline latency compensation runs only while oversampling is inactive.
// (R15) Timestamp advances on converter clock edges, not on the sample rate.
// (R16) Source field holds one valid code; the last valid write wins.
`timescale 1ns/10ps
module sample_clock_source_control import clk_src_pkg::*; #(
	parameter int TS_W = 48
) (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	output logic [DATA_W-1:0] reg_rdata_out,
	output logic reg_ack_out,
	input wire logic pll_clk_in,
	input wire logic pll_lock_in,
	input wire logic ext_clk_conn_in,
	output logic ext_clk_conn_out,
	output logic ext_clk_conn_oe_out,
	output logic term_50ohm_on_out,
	output logic pll_enable_out,
	output logic pll_ref_ext_sel_out,
	output logic pll_bypass_out,
	output logic [DATA_W-1:0] pll_ref_hz_out,
	output logic [DATA_W-1:0] pll_target_hz_out,
	output logic pll_load_out,
	output logic pll_locked_out,
	output logic pll_lock_timeout_out,
	output logic sample_tick_out,
	output logic latency_comp_en_out,
	output logic [TS_W-1:0] timestamp_out
);
	logic [DATA_W-1:0] clk_src_r;
	logic [DATA_W-1:0] ref_freq_r;
	logic [DATA_W-1:0] req_rate_r;
	logic term_r;
	logic clk_out_en_r;
	logic [DATA_W-1:0] ratio;
	logic mode_direct;
	logic mode_ext_ref;
	logic mode_int;
	logic wr_rate;
	logic pll_s1_r, pll_s2_r, ext_s1_r, ext_s2_r, lock_s1_r, lock_s2_r;
	logic conv_lvl;
	logic conv_lvl_d_r;
	logic conv_edge;
	logic [DATA_W-1:0] div_cnt_r;
	pll_state_e pll_state_r;
	logic [LOCK_CNT_W-1:0] lock_cnt_r;
	logic [63:0] target_full;

	assign mode_direct = (clk_src_r == MODE_DIRECT_EXT);
	assign mode_ext_ref = (clk_src_r == MODE_PLL_EXT_REF);
	assign mode_int = (clk_src_r == MODE_INT_PLL);
	assign wr_rate = reg_wr_in && (reg_addr_in == ADDR_REQ_RATE);

	// Register writes; the ratio address is read only and takes no write.
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			clk_src_r <= MODE_INT_PLL;
			ref_freq_r <= REF_RESET_HZ;
			req_rate_r <= RATE_RESET_HZ;
			term_r <= 1'b0;
			clk_out_en_r <= 1'b0;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				ADDR_CLK_SRC: begin
					if (reg_wdata_in == MODE_INT_PLL || reg_wdata_in == MODE_DIRECT_EXT ||
						reg_wdata_in == MODE_PLL_EXT_REF) begin
						clk_src_r <= reg_wdata_in; // R16
					end
				end
				ADDR_REF_FREQ: begin
					if (reg_wdata_in >= REF_MIN_HZ && reg_wdata_in <= REF_MAX_HZ) begin
						ref_freq_r <= reg_wdata_in; // R4
					end
				end
				ADDR_REQ_RATE: req_rate_r <= reg_wdata_in;
				ADDR_TERM: term_r <= reg_wdata_in[0]; // R8
				ADDR_CLK_OUT_EN: clk_out_en_r <= reg_wdata_in[0];
				default: begin
				end
			endcase
		end
	end

	// Registered read port; unmapped addresses read zero.
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= DATA_ZERO;
			reg_ack_out <= 1'b0;
		end else begin
			reg_ack_out <= reg_rd_in || reg_wr_in;
			if (reg_rd_in) begin
				case (reg_addr_in)
					ADDR_CLK_SRC: reg_rdata_out <= clk_src_r;
					ADDR_REF_FREQ: reg_rdata_out <= ref_freq_r; // R4
					ADDR_REQ_RATE: reg_rdata_out <= req_rate_r;
					ADDR_TERM: reg_rdata_out <= {31'h00000000, term_r};
					ADDR_CLK_OUT_EN: reg_rdata_out <= {31'h00000000, clk_out_en_r};
					ADDR_RATIO: reg_rdata_out <= ratio; // R11
					default: reg_rdata_out <= DATA_ZERO;
				endcase
			end
		end
	end

	converter_ratio_calc #(
		.MIN_HZ(CONV_MIN_HZ)
	) u_ratio (
		.core_clk_in(core_clk_in),
		.resetn_in(resetn_in),
		.rate_in(req_rate_r),
		.ratio_out(ratio) // R12
	);

	// Pin synchronisers; only the second stage feeds logic.
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pll_s1_r <= 1'b0;
			pll_s2_r <= 1'b0;
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			lock_s1_r <= 1'b0;
			lock_s2_r <= 1'b0;
		end else begin
			pll_s1_r <= pll_clk_in;
			pll_s2_r <= pll_s1_r;
			ext_s1_r <= ext_clk_conn_in;
			ext_s2_r <= ext_s1_r;
			lock_s1_r <= pll_lock_in;
			lock_s2_r <= lock_s1_r;
		end
	end

	// Converter clock comes from the connector in direct mode, else from the PLL.
	assign conv_lvl = mode_direct ? ext_s2_r : pll_s2_r; // R2
	assign conv_edge = conv_lvl && !conv_lvl_d_r;

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			conv_lvl_d_r <= 1'b0;
		end else begin
			conv_lvl_d_r <= conv_lvl;
		end
	end

	// PLL source selection outputs.
	assign pll_enable_out = mode_ext_ref || mode_int; // R1
	assign pll_ref_ext_sel_out = mode_ext_ref; // R3
	assign pll_bypass_out = mode_direct; // R2
	assign term_50ohm_on_out = term_r && (mode_direct || mode_ext_ref); // R9
	assign pll_ref_hz_out = mode_ext_ref ? ref_freq_r : REF_RESET_HZ; // R3

	// PLL target is the converter clock: requested rate times the ratio.
	assign target_full = {32'h00000000, req_rate_r} * {32'h00000000, ratio};

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pll_target_hz_out <= RATE_RESET_HZ;
		end else begin
			pll_target_hz_out <= target_full[DATA_W-1:0]; // R7
		end
	end

	// Reprogramming sequence: load after a rate write, or a source write while idle, then wait lock.
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pll_state_r <= PLL_IDLE;
			lock_cnt_r <= '0;
			pll_lock_timeout_out <= 1'b0;
		end else begin
			case (pll_state_r)
				PLL_IDLE: begin
					if (wr_rate || (reg_wr_in && reg_addr_in == ADDR_CLK_SRC)) begin
						pll_state_r <= PLL_LOAD; // R7
					end
				end
				PLL_LOAD: begin
					lock_cnt_r <= '0;
					pll_lock_timeout_out <= 1'b0;
					pll_state_r <= PLL_WAIT_LOCK;
				end
				PLL_WAIT_LOCK: begin
					if (wr_rate) begin
						pll_state_r <= PLL_LOAD;
					end else if (lock_s2_r || mode_direct) begin
						pll_state_r <= PLL_IDLE;
					end else if (lock_cnt_r == LOCK_CNT_W'(LOCK_TIMEOUT_CYC - 1)) begin
						pll_lock_timeout_out <= 1'b1;
						pll_state_r <= PLL_IDLE;
					end else begin
						lock_cnt_r <= lock_cnt_r + 1'b1;
					end
				end
				default: pll_state_r <= PLL_IDLE;
			endcase
		end
	end

	assign pll_load_out = (pll_state_r == PLL_LOAD);
	assign pll_locked_out = lock_s2_r && (pll_state_r == PLL_IDLE) && !mode_direct;

	// Digital sample tick: one per ratio converter edges.
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			div_cnt_r <= DATA_ZERO;
			sample_tick_out <= 1'b0;
		end else begin
			sample_tick_out <= 1'b0;
			if (conv_edge) begin
				if (div_cnt_r >= ratio - RATIO_ONE) begin
					div_cnt_r <= DATA_ZERO;
					sample_tick_out <= 1'b1; // R10
				end else begin
					div_cnt_r <= div_cnt_r + RATIO_ONE;
				end
			end
		end
	end

	// Timestamp counts converter edges.
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			timestamp_out <= '0;
		end else if (conv_edge) begin
			timestamp_out <= timestamp_out + 1'b1; // R15
		end
	end

	// Compensation is lost while oversampling.
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			latency_comp_en_out <= 1'b1;
		end else begin
			latency_comp_en_out <= (ratio == RATIO_ONE); // R14
		end
	end

	// Clock output only with internal clocking; it carries the undivided clock.
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ext_clk_conn_out <= 1'b0;
			ext_clk_conn_oe_out <= 1'b0;
		end else begin
			ext_clk_conn_out <= pll_s2_r; // R13
			ext_clk_conn_oe_out <= clk_out_en_r && mode_int; // R13
		end
	end

	chk_src_valid_code: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R16
		mode_int || mode_direct || mode_ext_ref)
		else $error("source field holds an invalid code");
	chk_ext_ref_path: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R1
		mode_ext_ref |-> pll_enable_out && pll_ref_ext_sel_out && !pll_bypass_out)
		else $error("reference mode does not route connector to PLL");
	chk_direct_bypass: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R2
		mode_direct |-> pll_bypass_out && !pll_enable_out && !pll_ref_ext_sel_out)
		else $error("direct mode does not bypass the PLL");
	chk_ref_in_range: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R4
		reg_wr_in && reg_addr_in == ADDR_REF_FREQ && reg_wdata_in > REF_MAX_HZ
		|=> $stable(ref_freq_r))
		else $error("out of range reference accepted");
	chk_term_gated: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R9
		term_50ohm_on_out |-> term_r && !mode_int)
		else $error("termination on while connector not an input");
	chk_ratio_readonly: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R12
		reg_wr_in && reg_addr_in == ADDR_RATIO && $stable(req_rate_r) |=> $stable(ratio))
		else $error("write changed the ratio");
	chk_rate_loads_pll: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R7
		wr_rate |=> pll_load_out ##1 (pll_state_r == PLL_WAIT_LOCK))
		else $error("rate write did not reprogram the PLL");
	chk_ts_on_edge: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R15
		conv_edge |=> timestamp_out == $past(timestamp_out) + 1'b1)
		else $error("timestamp missed a converter edge");
	chk_comp_off: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R14
		ratio != RATIO_ONE |=> !latency_comp_en_out)
		else $error("compensation on while oversampling");
	chk_clk_out_int: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R13
		ext_clk_conn_oe_out |-> $past(mode_int) && $past(clk_out_en_r))
		else $error("clock driven out without internal clocking");
	chk_tick_from_edge: assert property (@(posedge core_clk_in) disable iff (!resetn_in) // R10
		sample_tick_out |-> $past(conv_edge))
		else $error("sample tick without converter edge");
endmodule // sample_clock_source_control

// *** dv/clk_gen_model.sv ***
// Purpose: Far-side stand-in for the connector clock generator and the PLL.
// Assumes: Both clocks stay far below the 40 MHz core clock.
// Notes: Each clock stands still low while its run input is low.
`timescale 1ns/10ps
module clk_gen_model #(
	parameter int LOCK_DLY = 20
) (
	input wire logic core_clk_in,
	input wire logic ext_run_in,
	input wire logic pll_run_in,
	input wire logic pll_load_in,
	output logic ext_clk_out,
	output logic pll_clk_out,
	output logic pll_lock_out
);
	int lock_cnt = 0;
	initial begin
		ext_clk_out = 1'b0;
		pll_clk_out = 1'b0;
	end
	always #130 ext_clk_out = ext_run_in ? ~ext_clk_out : 1'b0;
	always #110 pll_clk_out = pll_run_in ? ~pll_clk_out : 1'b0;
	// Lock drops on every reprogram and comes back after a fixed delay.
	always @(posedge core_clk_in) begin
		if (pll_load_in) begin
			lock_cnt <= LOCK_DLY;
		end else if (lock_cnt > 0) begin
			lock_cnt <= lock_cnt - 1;
		end
	end
	assign pll_lock_out = (lock_cnt == 0);
endmodule // clk_gen_model

// *** dv/tb_sample_clock_source_control.sv ***
// Purpose: Register-level test of the sample clock source control block.
// Assumes: Inputs change 2 ns after the rising core clock edge.
// Notes: The connector level merges the block's drive and the generator.
`timescale 1ns/10ps
`define CHK(g, e) chk_val(64'(g), 64'(e))
module tb_sample_clock_source_control import clk_src_pkg::*; ;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [DATA_W-1:0] wdata = '0;
	logic [DATA_W-1:0] rdata, ref_hz, target_hz;
	logic ack, pll_clk, pll_lock, gen_ext, conn_out, conn_oe, term, pll_en, ref_sel, bypass;
	logic load, locked, tick, lcomp, tmo, ext_run = 1'b0, pll_run = 1'b0;
	logic [47:0] ts, ts0;
	int mismatches = 0;
	int check_count = 0;
	int tick_cnt = 0;
	int tc0;
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (tick === 1'b1) tick_cnt++;
	sample_clock_source_control sample_clock_source_control_i (.core_clk_in(core_clk),
		.resetn_in(resetn), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_ack_out(ack), .pll_clk_in(pll_clk),
		.pll_lock_in(pll_lock), .ext_clk_conn_in(conn_oe ? conn_out : gen_ext),
		.ext_clk_conn_out(conn_out), .ext_clk_conn_oe_out(conn_oe), .term_50ohm_on_out(term),
		.pll_enable_out(pll_en), .pll_ref_ext_sel_out(ref_sel), .pll_bypass_out(bypass),
		.pll_ref_hz_out(ref_hz), .pll_target_hz_out(target_hz), .pll_load_out(load),
		.pll_locked_out(locked), .pll_lock_timeout_out(tmo), .sample_tick_out(tick),
		.latency_comp_en_out(lcomp), .timestamp_out(ts));
	clk_gen_model clk_gen_model_i (.core_clk_in(core_clk), .ext_run_in(ext_run),
		.pll_run_in(pll_run), .pll_load_in(load), .ext_clk_out(gen_ext),
		.pll_clk_out(pll_clk), .pll_lock_out(pll_lock));
	task automatic chk_val(input logic [63:0] g, input logic [63:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic test_done;
		if (mismatches == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk);
		#2;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge core_clk);
		#2;
		wr = 1'b0;
		`CHK(ack, 1'b1);
	endtask
	task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge core_clk);
		#2;
		addr = a;
		rd = 1'b1;
		@(posedge core_clk);
		#2;
		rd = 1'b0;
		`CHK(ack, 1'b1);
		`CHK(rdata, e);
	endtask
	task automatic settle_ts;
		repeat (8) @(posedge core_clk);
		ts0 = ts;
		tc0 = tick_cnt;
	endtask
	initial begin
		logic [DATA_W-1:0] v;
		int i;
		int k;
		logic seen;
		repeat (8) @(posedge core_clk);
		#2;
		resetn = 1'b1;
		`CHK(lcomp, 1'b1);
		read_chk(ADDR_CLK_SRC, MODE_INT_PLL);
		read_chk(ADDR_RATIO, RATIO_ONE);
		read_chk(20'h00100, DATA_ZERO);
		for (i = 0; i < 4; i++) begin
			v = (i < 2) ? REF_MIN_HZ : REF_MAX_HZ;
			write_reg(ADDR_REF_FREQ, (i == 0 || i == 2) ? v : ((i == 1) ? v - 1 : v + 1));
			read_chk(ADDR_REF_FREQ, v);
		end
		write_reg(ADDR_REF_FREQ, 32'h01312D00);
		write_reg(ADDR_CLK_SRC, MODE_PLL_EXT_REF);
		`CHK({pll_en, ref_sel, bypass}, 3'b110);
		`CHK(ref_hz, 32'h01312D00);
		write_reg(ADDR_CLK_SRC, 32'h00000005);
		read_chk(ADDR_CLK_SRC, MODE_PLL_EXT_REF);
		write_reg(ADDR_TERM, 32'h00000001);
		`CHK(term, 1'b1);
		write_reg(ADDR_CLK_SRC, MODE_DIRECT_EXT);
		`CHK({pll_en, ref_sel, bypass, term}, 4'b0011);
		`CHK(locked, 1'b0);
		write_reg(ADDR_CLK_SRC, MODE_INT_PLL);
		`CHK(term, 1'b0);
		`CHK(ref_hz, REF_RESET_HZ);
		write_reg(ADDR_REQ_RATE, 32'h0001E848);
		read_chk(ADDR_RATIO, 32'h00000008);
		`CHK(target_hz, CONV_MIN_HZ);
		`CHK(lcomp, 1'b0);
		write_reg(ADDR_RATIO, RATIO_ONE);
		read_chk(ADDR_RATIO, 32'h00000008);
		write_reg(ADDR_CLK_OUT_EN, 32'h00000001);
		@(posedge core_clk);
		#2;
		`CHK(conn_oe, 1'b1);
		settle_ts;
		#2;
		seen = 1'b0;
		pll_run = 1'b1;
		// Run the PLL clock for exactly 64 converter edges, then stop it.
		for (k = 0; k < 2000 && ts - ts0 < 64; k++) begin
			@(posedge core_clk);
			#2;
			if (conn_out === 1'b1) seen = 1'b1;
		end
		pll_run = 1'b0;
		`CHK(k < 2000, 1'b1);
		repeat (20) @(posedge core_clk);
		#2;
		`CHK(ts - ts0, 64);
		`CHK(tick_cnt - tc0, 8);
		`CHK(seen, 1'b1);
		`CHK({locked, tmo}, 2'b10);
		test_done;
	end
endmodule // tb_sample_clock_source_control
